// File: rtl/clt_regs.sv
// Charger discharge/termination, voltage and timer registers with host watchdog.
`timescale 1ns/100ps
`include "clt_params.svh"

module clt_regs
    import clt_pkg::*;
#(
    parameter logic [1:0]  OTP_WD_DEFAULT = 2'h1,
    parameter int unsigned TICK_CYCLES    = `CLT_WD_TICK_CYC
)(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output logic [7:0]       regRdData,
    input  wire logic        swRegReset,
    input  wire logic        wdRestart,
    input  wire logic        batteryDischarging,
    output logic [11:0]      dischargeLimitMa,
    output logic [7:0]       terminationCurrentHalfMa,
    output logic [12:0]      regulationVoltageMv,
    output logic [11:0]      prechargeThresholdMv,
    output logic [7:0]       rechargeOffsetMv,
    output logic [7:0]       watchdogPeriodS,
    output logic [4:0]       fastChargeHours,
    output logic             discharge_watchdog_enable,
    output logic             terminationEnable,
    output logic             safetyTimerEnable,
    output logic             post_termination_timer_enable,
    output logic             watchdogFault,
    output logic             watchdog_expiry_reset
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // The watchdog field takes its power-on value from the one-time
    // programmed default; reset and software reset load this byte, and
    // watchdog expiry loads its low seven bits but keeps the current bit 7.
    localparam clt_byte_t TMR_RST     = `CLT_TMR_RST;
    localparam clt_byte_t TMR_DEFAULT = {TMR_RST[7], OTP_WD_DEFAULT, TMR_RST[4:0]};
    localparam logic      WD_OTP_OFF  = (OTP_WD_DEFAULT == 2'h0);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    clt_byte_t currReg_q;
    clt_byte_t currReg_d;
    clt_byte_t voltReg_q;
    clt_byte_t voltReg_d;
    clt_byte_t tmrReg_q;
    clt_byte_t tmrReg_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;

    logic wdExpire;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    wire hitCurr = regWrEn && (regAddr == `CLT_OFS_CURR);
    wire hitVolt = regWrEn && (regAddr == `CLT_OFS_VOLT);
    wire hitTmr  = regWrEn && (regAddr == `CLT_OFS_TMR);

    // Code 0000 lies outside the valid discharge range, so a write
    // carrying it keeps the previous limit instead of storing it.
    wire [3:0] wrDschg    = regWrData[`CLT_DSCHG_MSB:`CLT_DSCHG_LSB];
    wire       dschgValid = (wrDschg != 4'h0);
    wire [3:0] keptDschg  = dschgValid ? wrDschg : currReg_q[`CLT_DSCHG_MSB:`CLT_DSCHG_LSB];
    wire clt_byte_t currWr = {keptDschg, regWrData[`CLT_TERM_MSB:`CLT_TERM_LSB]};

    // Software reset beats watchdog expiry, which beats a host write.
    always_comb begin
        currReg_d = currReg_q;
        voltReg_d = voltReg_q;
        tmrReg_d  = tmrReg_q;
        if (swRegReset) begin
            currReg_d = `CLT_CURR_RST;
            voltReg_d = `CLT_VOLT_RST;
            tmrReg_d  = TMR_DEFAULT;
        end else if (wdExpire) begin
            currReg_d = `CLT_CURR_RST;
            voltReg_d = `CLT_VOLT_RST;
            tmrReg_d  = {tmrReg_q[`CLT_WDDIS_BIT], TMR_DEFAULT[6:0]};
        end else begin
            if (hitCurr) begin
                currReg_d = currWr;
            end
            if (hitVolt) begin
                voltReg_d = regWrData;
            end
            if (hitTmr) begin
                tmrReg_d = regWrData;
            end
        end
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            currReg_q <= `CLT_CURR_RST;
            voltReg_q <= `CLT_VOLT_RST;
            tmrReg_q  <= TMR_DEFAULT;
        end else begin
            currReg_q <= currReg_d;
            voltReg_q <= voltReg_d;
            tmrReg_q  <= tmrReg_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data is registered: it shows the addressed byte one cycle
    // after the address, and zero for any other offset.
    assign rdData_d = (regAddr == `CLT_OFS_CURR) ? currReg_q :
                      (regAddr == `CLT_OFS_VOLT) ? voltReg_q :
                      (regAddr == `CLT_OFS_TMR)  ? tmrReg_q  : 8'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [11:0] decDschg;
    logic [7:0]  decTerm;
    logic [12:0] decVreg;
    logic [11:0] decVpre;
    logic [7:0]  decVrech;
    logic [7:0]  decWdS;
    logic [4:0]  decChgH;

    clt_decode u_decode (
        .currReg                  (currReg_q),
        .voltReg                  (voltReg_q),
        .tmrReg                   (tmrReg_q),
        .dischargeLimitMa         (decDschg),
        .terminationCurrentHalfMa (decTerm),
        .regulationVoltageMv      (decVreg),
        .prechargeThresholdMv     (decVpre),
        .rechargeOffsetMv         (decVrech),
        .watchdogPeriodS          (decWdS),
        .fastChargeHours          (decChgH)
    );

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic [11:0] dschgOut_q;
    logic [7:0]  termOut_q;
    logic [12:0] vregOut_q;
    logic [11:0] vpreOut_q;
    logic [7:0]  vrechOut_q;
    logic [7:0]  wdSOut_q;
    logic [4:0]  chgHOut_q;
    logic [3:0]  flagsOut_q;

    wire [3:0] flagsNow = {tmrReg_q[`CLT_WDDIS_BIT],
                           tmrReg_q[`CLT_ENTERM_BIT],
                           tmrReg_q[`CLT_ENTMR_BIT],
                           tmrReg_q[`CLT_TERMTMR_BIT]};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dschgOut_q <= 12'h000;
            termOut_q  <= 8'h00;
            vregOut_q  <= 13'h0000;
            vpreOut_q  <= 12'h000;
            vrechOut_q <= 8'h00;
            wdSOut_q   <= 8'h00;
            chgHOut_q  <= 5'h00;
            flagsOut_q <= 4'h0;
        end else begin
            dschgOut_q <= decDschg;
            termOut_q  <= decTerm;
            vregOut_q  <= decVreg;
            vpreOut_q  <= decVpre;
            vrechOut_q <= decVrech;
            wdSOut_q   <= decWdS;
            chgHOut_q  <= decChgH;
            flagsOut_q <= flagsNow;
        end
    end

    assign dischargeLimitMa              = dschgOut_q;
    assign terminationCurrentHalfMa      = termOut_q;
    assign regulationVoltageMv           = vregOut_q;
    assign prechargeThresholdMv          = vpreOut_q;
    assign rechargeOffsetMv              = vrechOut_q;
    assign watchdogPeriodS               = wdSOut_q;
    assign fastChargeHours               = chgHOut_q;
    assign discharge_watchdog_enable     = flagsOut_q[3];
    assign terminationEnable             = flagsOut_q[2];
    assign safetyTimerEnable             = flagsOut_q[1];
    assign post_termination_timer_enable = flagsOut_q[0];

    // ------------------------------------------------------------
    // Host watchdog
    // ------------------------------------------------------------
    // A prescaler makes one-second ticks; the seconds counter then
    // compares against the selected period, so no counter needs to
    // span the full tens of billions of clock cycles.
    clt_wd_state_t wdState_q;
    clt_wd_state_t wdState_d;
    logic [31:0]   tickCnt_q;
    logic [31:0]   tickCnt_d;
    logic [7:0]    secCnt_q;
    logic [7:0]    secCnt_d;
    logic          wdFault_q;
    logic          wdPulse_q;

    wire [1:0] wdCode   = tmrReg_q[`CLT_WD_MSB:`CLT_WD_LSB];
    wire       wdActive = (wdCode != 2'h0) &&
                          (!batteryDischarging || tmrReg_q[`CLT_WDDIS_BIT]);
    wire       tickDone = (tickCnt_q == 32'(TICK_CYCLES - 1));
    // A shortened period must not let the count run past its end and wrap.
    wire       secDone  = tickDone && (secCnt_q >= decWdS - 8'h01);
    wire       wdClear  = wdRestart || swRegReset || !wdActive;

    // ------------------------------------------------------------
    // Watchdog state machine
    // ------------------------------------------------------------
    always_comb begin
        wdState_d = wdState_q;
        tickCnt_d = tickCnt_q;
        secCnt_d  = secCnt_q;
        wdExpire  = 1'b0;
        unique case (wdState_q)
            WD_OFF: begin
                tickCnt_d = 32'h0000_0000;
                secCnt_d  = 8'h00;
                if (wdActive && !wdClear) begin
                    wdState_d = WD_OTP_OFF ? WD_SUPPRESSED : WD_RUN;
                end
            end
            WD_RUN, WD_SUPPRESSED: begin
                if (wdClear) begin
                    wdState_d = WD_OFF;
                    tickCnt_d = 32'h0000_0000;
                    secCnt_d  = 8'h00;
                end else if (secDone) begin
                    // Suppressed expiry restarts the count silently.
                    wdExpire  = (wdState_q == WD_RUN);
                    wdState_d = WD_OFF;
                    tickCnt_d = 32'h0000_0000;
                    secCnt_d  = 8'h00;
                end else if (tickDone) begin
                    tickCnt_d = 32'h0000_0000;
                    secCnt_d  = secCnt_q + 8'h01;
                end else begin
                    tickCnt_d = tickCnt_q + 32'h0000_0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdState_q <= WD_OFF;
            tickCnt_q <= 32'h0000_0000;
            secCnt_q  <= 8'h00;
        end else begin
            wdState_q <= wdState_d;
            tickCnt_q <= tickCnt_d;
            secCnt_q  <= secCnt_d;
        end
    end

    // ------------------------------------------------------------
    // Watchdog flags
    // ------------------------------------------------------------
    // The fault flag is cleared by a restart, but an expiry in the
    // same cycle wins so the event is never lost.
    wire wdFault_d = wdExpire | (wdFault_q & ~wdRestart);
    wire wdPulse_d = wdExpire;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdFault_q <= 1'b0;
            wdPulse_q <= 1'b0;
        end else begin
            wdFault_q <= wdFault_d;
            wdPulse_q <= wdPulse_d;
        end
    end

    assign watchdogFault         = wdFault_q;
    assign watchdog_expiry_reset = wdPulse_q;

endmodule // clt_regs

// File: rtl/clt_params.svh
// Offsets, field positions, reset values and timing constants of the charger limit/timer registers.
`ifndef CLT_PARAMS_SVH
`define CLT_PARAMS_SVH

`define CLT_OFS_CURR          8'h03
`define CLT_OFS_VOLT          8'h04
`define CLT_OFS_TMR           8'h05

`define CLT_CURR_RST          8'hF1
`define CLT_VOLT_RST          8'hA3
`define CLT_TMR_RST           8'h38

`define CLT_DSCHG_MSB         7
`define CLT_DSCHG_LSB         4
`define CLT_TERM_MSB          3
`define CLT_TERM_LSB          0
`define CLT_VREG_MSB          7
`define CLT_VREG_LSB          2
`define CLT_VPRE_BIT          1
`define CLT_VRECH_BIT         0
`define CLT_WDDIS_BIT         7
`define CLT_WD_MSB            6
`define CLT_WD_LSB            5
`define CLT_ENTERM_BIT        4
`define CLT_ENTMR_BIT         3
`define CLT_CHGTMR_MSB        2
`define CLT_CHGTMR_LSB        1
`define CLT_TERMTMR_BIT       0

`define CLT_DSCHG_STEP_MA     12'd200
`define CLT_TERM_LO_OFS_HMA   8'd5
`define CLT_TERM_LO_STEP_HMA  8'd10
`define CLT_TERM_HI_OFS_HMA   8'd4
`define CLT_TERM_HI_STEP_HMA  8'd8
`define CLT_VREG_OFS_MV       13'd3600
`define CLT_VREG_STEP_MV      13'd15
`define CLT_VPRE_LO_MV        12'd2800
`define CLT_VPRE_HI_MV        12'd3000
`define CLT_VRECH_LO_MV       8'd100
`define CLT_VRECH_HI_MV       8'd200
`define CLT_WD_P1_S           8'd40
`define CLT_WD_P2_S           8'd80
`define CLT_WD_P3_S           8'd160
`define CLT_CHG_H0            5'd20
`define CLT_CHG_H1            5'd5
`define CLT_CHG_H2            5'd8
`define CLT_CHG_H3            5'd12

`define CLT_CLK_HZ            200000000
`define CLT_WD_TICK_S         1
`define CLT_WD_TICK_CYC       (`CLT_WD_TICK_S * `CLT_CLK_HZ)

`endif

// File: rtl/clt_pkg.sv
// Types shared by the charger limit/timer register files.
package clt_pkg;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_RUN,
        WD_SUPPRESSED
    } clt_wd_state_t;

    typedef logic [7:0] clt_byte_t;

endpackage : clt_pkg

// File: rtl/clt_decode.sv
// Combinational decode of the three configuration bytes into setpoints.
`timescale 1ns/100ps
`include "clt_params.svh"

module clt_decode
    import clt_pkg::*;
(
    input  wire clt_byte_t   currReg,
    input  wire clt_byte_t   voltReg,
    input  wire clt_byte_t   tmrReg,
    output logic [11:0]      dischargeLimitMa,
    output logic [7:0]       terminationCurrentHalfMa,
    output logic [12:0]      regulationVoltageMv,
    output logic [11:0]      prechargeThresholdMv,
    output logic [7:0]       rechargeOffsetMv,
    output logic [7:0]       watchdogPeriodS,
    output logic [4:0]       fastChargeHours
);

    // ------------------------------------------------------------
    // Field decoders
    // ------------------------------------------------------------
    function automatic logic [7:0] termDecode(input logic [3:0] code);
        if (code <= 4'h3) begin
            termDecode = `CLT_TERM_LO_OFS_HMA + `CLT_TERM_LO_STEP_HMA * {4'h0, code};
        end else begin
            termDecode = `CLT_TERM_HI_OFS_HMA + `CLT_TERM_HI_STEP_HMA * {4'h0, code};
        end
    endfunction

    wire [3:0] dschgCode = currReg[`CLT_DSCHG_MSB:`CLT_DSCHG_LSB];
    wire [5:0] vregCode  = voltReg[`CLT_VREG_MSB:`CLT_VREG_LSB];
    wire [1:0] wdCode    = tmrReg[`CLT_WD_MSB:`CLT_WD_LSB];
    wire [1:0] chgCode   = tmrReg[`CLT_CHGTMR_MSB:`CLT_CHGTMR_LSB];

    assign dischargeLimitMa = `CLT_DSCHG_STEP_MA * ({8'h00, dschgCode} + 12'd1);
    assign terminationCurrentHalfMa = termDecode(currReg[`CLT_TERM_MSB:`CLT_TERM_LSB]);
    assign regulationVoltageMv = `CLT_VREG_OFS_MV + `CLT_VREG_STEP_MV * {7'h00, vregCode};
    assign prechargeThresholdMv = voltReg[`CLT_VPRE_BIT] ? `CLT_VPRE_HI_MV : `CLT_VPRE_LO_MV;
    assign rechargeOffsetMv = voltReg[`CLT_VRECH_BIT] ? `CLT_VRECH_HI_MV : `CLT_VRECH_LO_MV;
    assign watchdogPeriodS = (wdCode == 2'h0) ? 8'h00 :
                             (wdCode == 2'h1) ? `CLT_WD_P1_S :
                             (wdCode == 2'h2) ? `CLT_WD_P2_S : `CLT_WD_P3_S;
    assign fastChargeHours = (chgCode == 2'h0) ? `CLT_CHG_H0 :
                             (chgCode == 2'h1) ? `CLT_CHG_H1 :
                             (chgCode == 2'h2) ? `CLT_CHG_H2 : `CLT_CHG_H3;

endmodule // clt_decode

// File: testbench/clt_regs_props.sv
// Concurrent checks on the ports of the charger limit/timer register block.
`timescale 1ns/100ps
module clt_regs_props #(
    parameter logic [1:0]  OTP_WD_DEFAULT = 2'h1,
    parameter int unsigned TICK_CYCLES    = 2
)(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        regWrEn,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    input wire logic        swRegReset,
    input wire logic        wdRestart,
    input wire logic        batteryDischarging,
    input wire logic [11:0] dischargeLimitMa,
    input wire logic [7:0]  terminationCurrentHalfMa,
    input wire logic [12:0] regulationVoltageMv,
    input wire logic [11:0] prechargeThresholdMv,
    input wire logic [7:0]  rechargeOffsetMv,
    input wire logic [7:0]  watchdogPeriodS,
    input wire logic [4:0]  fastChargeHours,
    input wire logic        discharge_watchdog_enable,
    input wire logic        terminationEnable,
    input wire logic        safetyTimerEnable,
    input wire logic        post_termination_timer_enable,
    input wire logic        watchdogFault,
    input wire logic        watchdog_expiry_reset
);
    // ------------------------------------------------------------
    // Decode checked against read-back
    // ------------------------------------------------------------
    // Read data and setpoints sample the same stored byte, so a read of an offset validates its decode.
    logic [7:0] rdAddrQ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdAddrQ <= 8'h00;
        end else begin
            rdAddrQ <= regAddr;
        end
    end
    dsch_decode_a: assert property (rdAddrQ == 8'h03 |->
        dischargeLimitMa == (12'(regRdData[7:4]) + 12'h001) * 12'h0C8) else $error("discharge limit wrong");
    term_decode_a: assert property (rdAddrQ == 8'h03 |-> terminationCurrentHalfMa ==
        (regRdData[3:0] < 4'h4 ? 8'h05 + 8'h0A * regRdData[3:0] : 8'h04 + 8'h08 * regRdData[3:0]))
        else $error("termination current wrong");
    vreg_decode_a: assert property (rdAddrQ == 8'h04 |->
        regulationVoltageMv == 13'hE10 + 13'h00F * regRdData[7:2]) else $error("regulation voltage wrong");
    thresh_decode_a: assert property (rdAddrQ == 8'h04 |->
        prechargeThresholdMv == (regRdData[1] ? 12'hBB8 : 12'hAF0) && rechargeOffsetMv == (regRdData[0] ? 8'hC8 : 8'h64))
        else $error("thresholds wrong");
    timer_decode_a: assert property (rdAddrQ == 8'h05 |->
        watchdogPeriodS == (regRdData[6:5] == 2'h0 ? 8'h00 : 8'h14 << regRdData[6:5]) && fastChargeHours ==
        (regRdData[2:1] == 2'h0 ? 5'h14 : regRdData[2:1] == 2'h1 ? 5'h05 : regRdData[2:1] == 2'h2 ? 5'h08 : 5'h0C))
        else $error("timer decode wrong");
    ctl_bits_a: assert property (rdAddrQ == 8'h05 |-> {discharge_watchdog_enable, terminationEnable,
        safetyTimerEnable, post_termination_timer_enable} == {regRdData[7], regRdData[4:3], regRdData[0]})
        else $error("control bits wrong");
    reg_reset_a: assert property (swRegReset |-> ##2 dischargeLimitMa == 12'hC80 &&
        regulationVoltageMv == 13'h1068 && !discharge_watchdog_enable && safetyTimerEnable) else $error("soft reset wrong");
    expiry_restore_a: assert property (watchdog_expiry_reset && !$past(swRegReset) |=>
        dischargeLimitMa == 12'hC80 && $stable(discharge_watchdog_enable)) else $error("expiry restore wrong");
    fault_pulse_a: assert property (watchdog_expiry_reset |-> watchdogFault ##1 !watchdog_expiry_reset)
        else $error("expiry pulse wrong");
    otp_off_a: assert property (OTP_WD_DEFAULT == 2'h0 |-> !watchdogFault && !watchdog_expiry_reset)
        else $error("fault with period default off");
    wd_off_a: assert property ((watchdogPeriodS == 8'h00) [*3] |-> !watchdog_expiry_reset)
        else $error("expiry while disabled");
    fault_clear_a: assert property (wdRestart |=> !watchdogFault || watchdog_expiry_reset)
        else $error("fault not cleared");
    cover property (watchdog_expiry_reset);
    cover property (swRegReset);
    cover property (regWrEn && regAddr == 8'h03 && regWrData[7:4] == 4'h0);
endmodule // clt_regs_props

// File: testbench/clt_host_model.sv
// Host model that writes, reads and pulses the request lines of the register block.
`timescale 1ns/100ps
module clt_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    output logic            regWrEn,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    output logic            swRegReset,
    output logic            wdRestart
);
    // ------------------------------------------------------------
    // Bus tasks, all driven at the falling edge
    // ------------------------------------------------------------
    initial begin
        regWrEn    = 1'b0;
        regAddr    = 8'h00;
        regWrData  = 8'h00;
        swRegReset = 1'b0;
        wdRestart  = 1'b0;
    end
    // Released data is inverted so a stale byte can never pass for a fresh write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn   = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(negedge clk);
        regWrEn   = 1'b0;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        d = regRdData;
    endtask
    task automatic reg_reset;
        @(negedge clk);
        swRegReset = 1'b1;
        @(negedge clk);
        swRegReset = 1'b0;
    endtask
    task automatic kick;
        @(negedge clk);
        wdRestart = 1'b1;
        @(negedge clk);
        wdRestart = 1'b0;
    endtask
endmodule // clt_host_model

// File: testbench/tb_top.sv
// Self-checking bench for the charger limit/timer register block.
`timescale 1ns/100ps
module tb_top
    import clt_pkg::*;
;
    typedef struct packed {clt_byte_t a; clt_byte_t d; clt_byte_t r; logic [3:0] s; logic [15:0] e;} clt_row_t;
    localparam clt_row_t ROWS [20] = '{
        '{8'h03, 8'h10, 8'h10, 4'h0, 16'h0190}, '{8'h03, 8'h05, 8'h15, 4'h0, 16'h0190},
        '{8'h03, 8'hF0, 8'hF0, 4'h1, 16'h0005}, '{8'h03, 8'h13, 8'h13, 4'h1, 16'h0023},
        '{8'h03, 8'h14, 8'h14, 4'h1, 16'h0024}, '{8'h03, 8'h1F, 8'h1F, 4'h1, 16'h007C},
        '{8'h04, 8'hFC, 8'hFC, 4'h2, 16'h11C1}, '{8'h04, 8'h01, 8'h01, 4'h3, 16'h0AF0},
        '{8'h04, 8'h02, 8'h02, 4'h4, 16'h0064}, '{8'h04, 8'h01, 8'h01, 4'h4, 16'h00C8},
        '{8'h05, 8'h00, 8'h00, 4'h5, 16'h0000}, '{8'h05, 8'h20, 8'h20, 4'h5, 16'h0028},
        '{8'h05, 8'h40, 8'h40, 4'h5, 16'h0050}, '{8'h05, 8'h60, 8'h60, 4'h5, 16'h00A0},
        '{8'h05, 8'h22, 8'h22, 4'h6, 16'h0005}, '{8'h05, 8'h24, 8'h24, 4'h6, 16'h0008},
        '{8'h05, 8'h26, 8'h26, 4'h6, 16'h000C}, '{8'h05, 8'h99, 8'h99, 4'h7, 16'h000F},
        '{8'h05, 8'h81, 8'h81, 4'h7, 16'h0009}, '{8'h06, 8'hAA, 8'h00, 4'h7, 16'h0009}};
    logic        clk, rstn, batteryDischarging, regWrEn, swRegReset, wdRestart, faultOff;
    logic        discharge_watchdog_enable, terminationEnable, safetyTimerEnable, post_termination_timer_enable;
    logic        watchdogFault, watchdog_expiry_reset;
    logic [7:0]  regAddr, regWrData, regRdData, terminationCurrentHalfMa, rechargeOffsetMv, watchdogPeriodS;
    logic [11:0] dischargeLimitMa, prechargeThresholdMv;
    logic [12:0] regulationVoltageMv;
    logic [4:0]  fastChargeHours;
    clt_byte_t   v;
    int          errTotal, checkCount, n;
    clt_host_model i_host (.*);
    clt_regs #(.TICK_CYCLES(2)) i_dut (.*);
    clt_regs #(.OTP_WD_DEFAULT(2'h0), .TICK_CYCLES(2)) i_dut_otp (.*, .regRdData(), .dischargeLimitMa(),
        .terminationCurrentHalfMa(), .regulationVoltageMv(), .prechargeThresholdMv(), .rechargeOffsetMv(),
        .watchdogPeriodS(), .fastChargeHours(), .discharge_watchdog_enable(), .terminationEnable(),
        .safetyTimerEnable(), .post_termination_timer_enable(), .watchdogFault(faultOff), .watchdog_expiry_reset());
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] pick(input logic [3:0] s);
        case (s)
            4'h0: pick = 16'(dischargeLimitMa);
            4'h1: pick = 16'(terminationCurrentHalfMa);
            4'h2: pick = 16'(regulationVoltageMv);
            4'h3: pick = 16'(prechargeThresholdMv);
            4'h4: pick = 16'(rechargeOffsetMv);
            4'h5: pick = 16'(watchdogPeriodS);
            4'h6: pick = 16'(fastChargeHours);
            4'h7: pick = 16'({discharge_watchdog_enable, terminationEnable, safetyTimerEnable, post_termination_timer_enable});
            default: pick = 16'h0000;
        endcase
    endfunction
    // Bounded wait so a dead watchdog shows up as a wrong span, not a hang.
    task automatic wait_pulse;
        n = 0;
        while (watchdog_expiry_reset !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        completeRun();
    end
    initial begin
        rstn = 1'b0;
        batteryDischarging = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        foreach (ROWS[i]) begin
            i_host.kick();
            i_host.wr(ROWS[i].a, ROWS[i].d);
            i_host.rd(ROWS[i].a, v);
            check("readback", 16'(v), 16'(ROWS[i].r));
            check("decode", pick(ROWS[i].s), ROWS[i].e);
        end
        $display("table test done");
        i_host.wr(8'h05, 8'hA7);
        i_host.wr(8'h03, 8'h22);
        i_host.reg_reset();
        i_host.rd(8'h05, v);
        check("soft reset 05", 16'(v), 16'h0038);
        i_host.rd(8'h03, v);
        check("soft reset 03", 16'(v), 16'h00F1);
        $display("soft reset test done");
        i_host.wr(8'h05, 8'hA0);
        i_host.wr(8'h03, 8'h55);
        i_host.kick();
        wait_pulse();
        check("expiry span", 16'(n >= 78 && n <= 82), 16'h0001);
        check("fault", 16'(watchdogFault), 16'h0001);
        check("fault otp off", 16'(faultOff), 16'h0000);
        i_host.rd(8'h05, v);
        check("expiry 05", 16'(v), 16'h00B8);
        i_host.rd(8'h03, v);
        check("expiry 03", 16'(v), 16'h00F1);
        i_host.kick();
        check("fault cleared", 16'(watchdogFault), 16'h0000);
        $display("expiry test done");
        batteryDischarging = 1'b1;
        i_host.wr(8'h05, 8'h20);
        i_host.kick();
        repeat (200) @(negedge clk);
        check("discharge idle", 16'(watchdogFault), 16'h0000);
        i_host.wr(8'h05, 8'hA0);
        wait_pulse();
        check("discharge span", 16'(n >= 78 && n <= 82), 16'h0001);
        $display("discharge test done");
        rstn = 1'b0;
        @(negedge clk);
        check("reset limit", 16'(dischargeLimitMa), 16'h0000);
        check("reset fault", 16'(watchdogFault), 16'h0000);
        rstn = 1'b1;
        i_host.rd(8'h04, v);
        check("reset 04", 16'(v), 16'h00A3);
        check("reset vreg", pick(4'h2), 16'h1068);
        check("reset term", pick(4'h1), 16'h000F);
        check("reset limit", pick(4'h0), 16'h0C80);
        check("reset bits", pick(4'h7), 16'h0006);
        check("reset timers", {watchdogPeriodS, 3'h0, fastChargeHours}, 16'h2814);
        $display("reset test done");
        completeRun();
    end
endmodule // tb_top
bind clt_regs clt_regs_props #(.OTP_WD_DEFAULT(OTP_WD_DEFAULT), .TICK_CYCLES(TICK_CYCLES)) i_props (.*);
